// ---- hw/lsd_pkg.sv ----
// =====================================================================
// low supply detect control: shared constants
// =====================================================================
package lsd_pkg;
   // register byte offsets (one aligned word each)
   localparam logic [7:0] RESET_CONTROL_REG_OFF = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_REG2_OFF = 8'h04;
   localparam logic [7:0] IRQ_FLAG_REG2_OFF = 8'h08;
   localparam logic [7:0] IRQ_PRIORITY_REG10_OFF = 8'h0c;
   // field positions
   localparam int REFERENCE_STABLE_BIT = 13;
   localparam int DETECTOR_ENABLE_BIT = 12;
   localparam int TRIP_LEVEL_LSB = 8;
   localparam int LOW_SUPPLY_IRQ_ENABLE_BIT = 10;
   localparam int LOW_SUPPLY_FLAG_BIT = 10;
   localparam int LOW_SUPPLY_PRIO_LSB = 8;
   // values after reset
   localparam logic [3:0] TRIP_LEVEL_RESET = 4'h5;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   // trip code that routes the external pin to the comparator
   localparam logic [3:0] TRIP_LEVEL_EXTERNAL = 4'hf;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lsd_pkg

// ---- hw/lsd_top.sv ----
// Functional notes
// - enable bit powers detector on and off
// - low supply flag sticky until software clears
// - detector keeps working in sleep, idle
// - enabled flag wakes core from power save
// - low priority wake resumes next instruction
// - higher priority wake starts exception processing
// - reference powered while any user enabled
// - reference stable bit is read only status
// - code 1111 selects external sense input
// - trip level resets to 0101
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module lsd_top #(
   parameter int ADDR_W = 8
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog side (asynchronous inputs)
   input wire logic comparator_below,
   input wire logic bandgap_ready,
   input wire logic brownout_unit_enabled,
   // analog side controls
   output logic detector_power,
   output logic reference_power,
   output logic [3:0] tap_select,
   output logic external_sense_select,
   // cpu side (same clock)
   input wire logic power_save_active,
   input wire logic [2:0] cpu_priority,
   output logic irq_request,
   output logic [2:0] irq_priority,
   output logic wake_pulse,
   output logic resume_next_pulse,
   output logic exception_pulse
);

   // =================================================================
   // state
   // =================================================================
   typedef struct packed {
      // synchronisers, stage one read only by stage two
      logic cmp_s1;
      logic cmp_s2;
      logic bg_s1;
      logic bg_s2;
      logic bor_s1;
      logic bor_s2;
      // control fields
      logic det_en;
      logic [3:0] trip_level;
      logic irq_en;
      logic flag;
      logic [2:0] prio;
      // registered outputs
      logic ref_pwr;
      logic irq_req;
      logic wake;
      logic resume;
      logic exc;
      logic ext_sel; // external pin routed to the comparator
      // write channel
      logic aw_have;
      logic w_have;
      logic [ADDR_W-1:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      // read channel
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } lsd_state_t;

   lsd_state_t st_q; // registered state
   lsd_state_t st_d; // next state

   // =================================================================
   // address decode: {hit, index}
   // =================================================================
   function automatic logic [2:0] lsd_decode(input logic [ADDR_W-1:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a == ADDR_W'(lsd_pkg::RESET_CONTROL_REG_OFF)) begin
         r = 3'h4;
      end else if (a == ADDR_W'(lsd_pkg::IRQ_ENABLE_REG2_OFF)) begin
         r = 3'h5;
      end else if (a == ADDR_W'(lsd_pkg::IRQ_FLAG_REG2_OFF)) begin
         r = 3'h6;
      end else if (a == ADDR_W'(lsd_pkg::IRQ_PRIORITY_REG10_OFF)) begin
         r = 3'h7;
      end
      return r;
   endfunction

   // merge a byte-lane write into a 16-bit register image
   function automatic logic [15:0] lsd_merge(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = nw[7:0];
      end
      if (strb[1]) begin
         r[15:8] = nw[15:8];
      end
      return r;
   endfunction

   // =================================================================
   // next-state logic
   // =================================================================
   always_comb begin
      logic [2:0] wsel;
      logic [2:0] rsel;
      logic [15:0] img;
      logic [15:0] rimg;
      logic flag_clr;
      logic flag_wr;
      logic do_write;
      logic ref_stable;
      wsel = 3'h0;
      rsel = 3'h0;
      img = 16'h0000;
      rimg = 16'h0000;
      flag_clr = 1'b0;
      flag_wr = 1'b0;
      do_write = 1'b0;
      st_d = st_q;

      // two-flop synchronisers for the analog levels
      st_d.cmp_s1 = comparator_below;
      st_d.cmp_s2 = st_q.cmp_s1;
      st_d.bg_s1 = bandgap_ready;
      st_d.bg_s2 = st_q.bg_s1;
      st_d.bor_s1 = brownout_unit_enabled;
      st_d.bor_s2 = st_q.bor_s1;

      // stable only while the reference is actually powered
      ref_stable = st_q.bg_s2 & st_q.ref_pwr;

      // capture write address and data in either order
      if (st_q.awready && s_axi_awvalid) begin
         st_d.aw_have = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (st_q.wready && s_axi_wvalid) begin
         st_d.w_have = 1'b1;
         st_d.wdata = s_axi_wdata[15:0];
         st_d.wstrb = s_axi_wstrb[1:0];
      end

      // perform the write once both halves are held
      if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
         do_write = 1'b1;
         wsel = lsd_decode(st_q.awaddr);
         st_d.aw_have = 1'b0;
         st_d.w_have = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = wsel[2] ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
      end else if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      if (do_write) begin
         case (wsel)
            3'h4: begin
               img = {3'b000, st_q.det_en, st_q.trip_level, 8'h00};
               img = lsd_merge(img, st_q.wdata, st_q.wstrb);
               st_d.det_en = img[lsd_pkg::DETECTOR_ENABLE_BIT];
               st_d.trip_level = img[lsd_pkg::TRIP_LEVEL_LSB +: 4];
            end
            3'h5: begin
               img = 16'h0000;
               img[lsd_pkg::LOW_SUPPLY_IRQ_ENABLE_BIT] = st_q.irq_en;
               img = lsd_merge(img, st_q.wdata, st_q.wstrb);
               st_d.irq_en = img[lsd_pkg::LOW_SUPPLY_IRQ_ENABLE_BIT];
            end
            3'h6: begin
               img = 16'h0000;
               img[lsd_pkg::LOW_SUPPLY_FLAG_BIT] = st_q.flag;
               img = lsd_merge(img, st_q.wdata, st_q.wstrb);
               flag_wr = 1'b1;
               flag_clr = ~img[lsd_pkg::LOW_SUPPLY_FLAG_BIT];
            end
            3'h7: begin
               img = {5'h00, st_q.prio, 8'h00};
               img = lsd_merge(img, st_q.wdata, st_q.wstrb);
               st_d.prio = img[lsd_pkg::LOW_SUPPLY_PRIO_LSB +: 3];
            end
            default: begin
               // unmapped: nothing stored, slverr answered
            end
         endcase
      end

      // sticky flag: hardware set beats a same-cycle software clear
      if (st_q.det_en && st_q.cmp_s2) begin
         st_d.flag = 1'b1;
      end else if (flag_wr) begin
         st_d.flag = ~flag_clr;
      end

      // reference kept up for any of its users
      st_d.ref_pwr = st_d.det_en | st_q.bor_s2;
      // pin route registered so the select port comes from a flop
      st_d.ext_sel = (st_d.trip_level == lsd_pkg::TRIP_LEVEL_EXTERNAL);

      // interrupt request as a level, wake decisions as one-cycle pulses
      st_d.irq_req = st_q.flag & st_q.irq_en;
      st_d.wake = 1'b0;
      st_d.resume = 1'b0;
      st_d.exc = 1'b0;
      if (power_save_active && st_q.flag && st_q.irq_en && !st_q.wake) begin
         st_d.wake = 1'b1;
         if (st_q.prio > cpu_priority) begin
            st_d.exc = 1'b1;
         end else begin
            st_d.resume = 1'b1;
         end
      end

      // read channel: one outstanding read, data latched at accept
      if (st_q.arready && s_axi_arvalid) begin
         rsel = lsd_decode(s_axi_araddr);
         case (rsel)
            3'h4: begin
               rimg[lsd_pkg::REFERENCE_STABLE_BIT] = ref_stable;
               rimg[lsd_pkg::DETECTOR_ENABLE_BIT] = st_q.det_en;
               rimg[lsd_pkg::TRIP_LEVEL_LSB +: 4] = st_q.trip_level;
            end
            3'h5: rimg[lsd_pkg::LOW_SUPPLY_IRQ_ENABLE_BIT] = st_q.irq_en;
            3'h6: rimg[lsd_pkg::LOW_SUPPLY_FLAG_BIT] = st_q.flag;
            3'h7: rimg[lsd_pkg::LOW_SUPPLY_PRIO_LSB +: 3] = st_q.prio;
            default: rimg = 16'h0000;
         endcase
         st_d.rdata = {16'h0000, rimg};
         st_d.rresp = rsel[2] ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
         st_d.rvalid = 1'b1;
      end else if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end

      // ready flags computed ahead so the ports come from flops
      st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
      st_d.wready = ~st_d.w_have & ~st_d.bvalid;
      st_d.arready = ~st_d.rvalid;
   end

   // =================================================================
   // state register
   // =================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.trip_level <= lsd_pkg::TRIP_LEVEL_RESET;
         st_q.prio <= lsd_pkg::PRIO_RESET;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // =================================================================
   // outputs, all straight from the state register
   // =================================================================
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
   assign detector_power = st_q.det_en;
   assign reference_power = st_q.ref_pwr;
   assign tap_select = st_q.trip_level;
   assign external_sense_select = st_q.ext_sel;
   assign irq_request = st_q.irq_req;
   assign irq_priority = st_q.prio;
   assign wake_pulse = st_q.wake;
   assign resume_next_pulse = st_q.resume;
   assign exception_pulse = st_q.exc;

endmodule // lsd_top

`default_nettype wire

// ---- testbench/lsd_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// analog comparator, bandgap and cpu power-save model
module lsd_far_model #(
   parameter int BG_DLY = 20
) (
   // clock
   input wire logic aclk,
   // controls from the block
   input wire logic detector_power,
   input wire logic reference_power,
   input wire logic [3:0] tap_select,
   input wire logic external_sense_select,
   input wire logic wake_pulse,
   // bench knobs
   input wire logic [3:0] supply_lvl,
   input wire logic ext_low,
   input wire logic sleep_req,
   // answers
   output logic comparator_below,
   output var logic bandgap_ready,
   output var logic power_save_active
);
   int bg_cnt = 0; // cycles since the reference came up
   // unclocked comparator: 7 ns skew keeps its edges off the clock
   assign #7 comparator_below = detector_power
      && (external_sense_select ? ext_low : supply_lvl < tap_select);
   initial power_save_active = 1'b0;
   // bandgap settles only while powered, core sleeps until woken
   always @(posedge aclk) begin
      bg_cnt <= reference_power ? bg_cnt + 1 : 0;
      power_save_active <= !wake_pulse && (sleep_req || power_save_active);
   end
   assign bandgap_ready = bg_cnt > BG_DLY;
endmodule // lsd_far_model
`default_nettype wire

// ---- testbench/lsd_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// port checks: bus timing, wake decision, flag causes
module lsd_properties #(
   parameter int ADDR_W = 8
) (
   // clock, reset, register bus
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [1:0] s_axi_rresp,
   // analog and cpu side
   input wire logic comparator_below, detector_power, reference_power, external_sense_select,
   input wire logic power_save_active, irq_request, wake_pulse, resume_next_pulse,
   input wire logic exception_pulse,
   input wire logic [3:0] tap_select,
   input wire logic [2:0] cpu_priority, irq_priority
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // core asleep, then woken
   sequence s_sleep_wake;
      power_save_active ##1 wake_pulse;
   endsequence
   a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read late");
   a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
      |=> s_axi_rresp == lsd_pkg::RESP_SLVERR) else $error("unmapped read accepted");
   a_ref_power: assert property (
      detector_power && $past(detector_power) |-> reference_power) else $error("ref off");
   a_ext_route: assert property (
      external_sense_select == (tap_select == lsd_pkg::TRIP_LEVEL_EXTERNAL))
      else $error("pin route wrong");
   a_flag_sticky: assert property (
      $fell(irq_request) |-> $past(s_axi_bvalid)) else $error("flag dropped alone");
   a_flag_sync: assert property (
      $rose(irq_request) |-> $past(comparator_below, 4) || $past(s_axi_bvalid))
      else $error("flag set early");
   a_wake_cause: assert property (
      wake_pulse |-> $past(power_save_active)) else $error("wake while awake");
   a_wake_single: assert property (
      s_sleep_wake |=> !wake_pulse) else $error("wake repeated");
   a_resume_prio: assert property (
      wake_pulse |-> resume_next_pulse == (irq_priority <= $past(cpu_priority)))
      else $error("resume wrong");
   a_exc_prio: assert property (
      wake_pulse |-> exception_pulse == (irq_priority > $past(cpu_priority)))
      else $error("exception wrong");
endmodule // lsd_properties
bind lsd_top lsd_properties #(.ADDR_W(ADDR_W)) u_lsd_properties (.*);
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// bench: axi master, integer register model, scenarios
module tb_top;
   // design and partner signals
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, ext_low = 1'b0, sleep_req = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, brownout_unit_enabled = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, cpu_priority = 3'h0, irq_priority;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h3, supply_lvl = 4'ha, tap_select;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic comparator_below, bandgap_ready, detector_power, reference_power, external_sense_select;
   logic power_save_active, irq_request, wake_pulse, resume_next_pulse, exception_pulse;
   // model state and tallies
   int n_errors = 0, samples_checked = 0, seed = 89, n_wake = 0, i, p, cp;
   int m_en = 0, m_trip = 5, m_ie = 0, m_flag = 0, m_prio = 4, m_bg = 0;
   lsd_top u_lsd_top (.*);
   lsd_far_model u_lsd_far_model (.*);
   // 20 mhz clock
   initial begin
      forever #25 aclk = ~aclk;
   end
   // wake pulses seen so far
   always @(posedge aclk) begin
      if (wake_pulse === 1'b1) n_wake++;
   end
   // one compare for every value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // axi write: halves offered together, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rd_resp = s_axi_bresp;
      @(posedge aclk);
   endtask
   // axi read; the extra edge keeps strobes from toggling twice
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
   endtask
   // expected register word from the model
   function automatic logic [31:0] mx(input logic [7:0] a);
      case (a)
         8'h00: return m_bg << 13 | m_en << 12 | m_trip << 8;
         8'h04: return m_ie << 10;
         8'h08: return m_flag << 10;
         8'h0c: return m_prio << 8;
         default: return 32'h0;
      endcase
   endfunction
   // write a register, track it, check the response
   task automatic mw(input logic [7:0] a, input logic [31:0] d);
      if (a == 8'h00) m_en = d[12];
      if (a == 8'h00) m_trip = d[11:8];
      if (a == 8'h04) m_ie = d[10];
      if (a == 8'h08) m_flag = d[10];
      if (a == 8'h0c) m_prio = d[10:8];
      wr(a, d);
      chk($sformatf("bresp %h", a), a > 8'h0c ? 2'h2 : 2'h0, rd_resp);
   endtask
   // read a register and compare with the model
   task automatic rc(input logic [7:0] a);
      rd(a);
      chk($sformatf("reg %h", a), mx(a), rd_data);
      chk($sformatf("rresp %h", a), a > 8'h0c ? 2'h2 : 2'h0, rd_resp);
   endtask
   // verdict
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out();
   end
   // =====================================================
   // scenarios
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i <= 16; i += 4) rc(8'(i));
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         mw(8'h00, i << 8);
         chk("tap_select", i, tap_select);
         chk("ext_select", i == 15, external_sense_select);
      end
      brownout_unit_enabled <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("reference_power", 1, reference_power);
      chk("detector_power", 0, detector_power);
      brownout_unit_enabled <= 1'b0;
      mw(8'h00, 32'h1800);
      chk("detector_power", 1, detector_power);
      for (i = 0; i < 60 && !rd_data[13]; i++) rd(8'h00);
      m_bg = 1;
      mw(8'h00, 32'h1800);
      rc(8'h00);
      $display("test enable done");
      // dip below the tap: flag latches and outlives the dip
      mw(8'h08, 0);
      supply_lvl <= 4'h5;
      repeat (8) @(posedge aclk);
      supply_lvl <= 4'ha;
      m_flag = 1;
      repeat (8) @(posedge aclk);
      rc(8'h08);
      mw(8'h08, 0);
      mw(8'h00, 32'h1f00);
      repeat (8) @(posedge aclk);
      rc(8'h08);
      ext_low <= 1'b1;
      repeat (8) @(posedge aclk);
      mw(8'h08, 0);
      m_flag = 1;
      rc(8'h08);
      ext_low <= 1'b0;
      mw(8'h00, 32'h1800);
      mw(8'h08, 0);
      $display("test flag done");
      // masked interrupt: a dip in sleep sets the flag but never wakes
      sleep_req <= 1'b1;
      @(posedge aclk);
      sleep_req <= 1'b0;
      supply_lvl <= 4'h5;
      i = n_wake;
      repeat (20) @(posedge aclk);
      chk("wake count", i, n_wake);
      m_flag = 1;
      rc(8'h08);
      supply_lvl <= 4'ha;
      repeat (4) @(posedge aclk);
      mw(8'h08, 0);
      for (p = 0; p < 8; p++) begin
         cp = {$random(seed)} % 7;
         cpu_priority <= 3'(cp);
         mw(8'h04, 0);
         mw(8'h0c, p << 8);
         mw(8'h04, 32'h400);
         sleep_req <= 1'b1;
         @(posedge aclk);
         sleep_req <= 1'b0;
         supply_lvl <= 4'h5;
         for (i = 0; i < 40 && wake_pulse !== 1'b1; i++) @(posedge aclk);
         chk("wake", 1, wake_pulse);
         chk("resume", p <= cp, resume_next_pulse);
         chk("exception", p > cp, exception_pulse);
         chk("irq_request", 1, irq_request);
         chk("irq_priority", p, irq_priority);
         // handler follows the supply down, then clears
         mw(8'h00, 32'h1400);
         mw(8'h08, 0);
         rc(8'h08);
         supply_lvl <= 4'ha;
         mw(8'h00, 32'h1800);
      end
      $display("test wake done");
      // clock enable low: a dip must not reach the flag until it returns
      clk_en <= 1'b0;
      supply_lvl <= 4'h5;
      repeat (10) @(posedge aclk);
      chk("irq_request frozen", 0, irq_request);
      clk_en <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("irq_request thawed", 1, irq_request);
      supply_lvl <= 4'ha;
      repeat (4) @(posedge aclk);
      mw(8'h08, 0);
      rc(8'h08);
      $display("test clock enable done");
      mw(8'h40, 32'hffff);
      rc(8'h40);
      mw(8'h00, 32'h0500);
      m_bg = 0;
      chk("detector_power", 0, detector_power);
      rc(8'h00);
      $display("test unmapped and disable done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
